// [logic/rrp_map.svh]
// Purpose: offsets, fields, reset values and timing counts
// Assumes: mclk at 20 MHz
// Notes:   counts are derived from the printed times
`ifndef RRP_MAP_SVH
`define RRP_MAP_SVH
`define RRP_MCLK_KHZ 20000
`define RRP_MCLK_HZ 20000000
`define RRP_TRST_MS 250
`define RRP_POWER_UP_RECOVERY_DELAY_MS 250
`define RRP_TPBDB_MS 250
`define RRP_TOSF_MS 100
`define RRP_RST_CYC (`RRP_TRST_MS * `RRP_MCLK_KHZ)
`define RRP_REC_CYC (`RRP_POWER_UP_RECOVERY_DELAY_MS * `RRP_MCLK_KHZ)
`define RRP_DEB_CYC (`RRP_TPBDB_MS * `RRP_MCLK_KHZ)
`define RRP_OSF_CYC (`RRP_TOSF_MS * `RRP_MCLK_KHZ)
`define RRP_RATE0_HZ 1
`define RRP_RATE1_HZ 1024
`define RRP_RATE2_HZ 4096
`define RRP_RATE3_HZ 8192
`define RRP_HALF(hz) (`RRP_MCLK_HZ / (2 * (hz)))
`define RRP_OFF_CTRL 8'h00
`define RRP_OFF_STAT 8'h04
`define RRP_OFF_ISTAT 8'h08
`define RRP_OFF_ICLR 8'h0C
`define RRP_OFF_IEN 8'h10
`define RRP_C_A1EN 0
`define RRP_C_A2EN 1
`define RRP_C_IOW 2
`define RRP_C_RSLO 3
`define RRP_C_RSHI 4
`define RRP_C_REFEN 5
`define RRP_C_ODIS 7
`define RRP_CTRL_RST 8'h24
`define RRP_EV_A1 0
`define RRP_EV_A2 1
`define RRP_EV_PF 2
`define RRP_EV_PB 3
`define RRP_EV_OS 4
`define RRP_IEN_RST 5'h00
`define RRP_S_OSF 0
`define RRP_S_DRV 1
`define RRP_S_SUP 2
`define RRP_S_ALIVE 3
`define RRP_GUARD 2'h3
`define RRP_RESP_OK 2'h0
`define RRP_RESP_ERR 2'h2
`endif

// [logic/rrp_pkg.sv]
// Purpose: types of the reset and pin block
// Assumes: nothing
// Notes:   one-hot state codes
package rrp_pkg;
  typedef enum logic [4:0]
  {
    ST_IDLE  = 5'h01,
    ST_DEB   = 5'h02,
    ST_FAIL  = 5'h04,
    ST_REC   = 5'h08,
    ST_PULSE = 5'h10
  } rrp_state_t;
endpackage

// [logic/rrp_pins.sv]
// Purpose: reset pin, interrupt/wave pin, stop flag, ref clock out
// Assumes: pins and refClkIn arrive asynchronously
// Notes:   registers over AXI4-Lite, low byte lane only
//
// How it works
// - With the select bit clear the shared pin carries a square wave at the chosen rate.
// - With the select bit set the shared pin goes low on an enabled alarm match.
// - After power-on reset the select bit is set and both alarms are disabled.
// - The reset pin is held low while supply is bad and released after the recovery delay.
// - A debounced low on the reset pin from outside produces a full reset pulse.
// - The recovery delay before release applies only with the oscillator enabled and running.
// - With the oscillator disabled the reset pin is released at once after supply returns.
// - The reset pin level never resets this logic or the counters.
// - The stop flag sets only after the oscillator has been stopped for the full period.
// - That stop detection period is 100 ms.
// - The reference clock output keeps running while enabled, on either supply.
//
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "rrp_map.svh"
module rrp_pins
#(
  parameter logic [23:0] RST_CYC  = 24'(`RRP_RST_CYC),
  parameter logic [23:0] REC_CYC  = 24'(`RRP_REC_CYC),
  parameter logic [23:0] DEB_CYC  = 24'(`RRP_DEB_CYC),
  parameter logic [23:0] OSF_CYC  = 24'(`RRP_OSF_CYC),
  parameter logic [23:0] W0_HALF  = 24'(`RRP_HALF(`RRP_RATE0_HZ)),
  parameter logic [23:0] W1_HALF  = 24'(`RRP_HALF(`RRP_RATE1_HZ))
)
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        supplyOk,
  input  wire logic        alarm1Match,
  input  wire logic        alarm2Match,
  input  wire logic        refClkIn,
  input  wire logic        rstPinIn,
  output logic             rstPinOut,
  output logic             rstPinOe,
  output logic             intPinOut,
  output logic             intPinOe,
  output logic             refClkPinOut,
  output logic             refClkPinOe,
  output logic             irq
);
  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  logic [2:0] syncA;
  logic [2:0] syncB;
  logic       refPrev;
  wire logic  supOk  = syncB[0];
  wire logic  pinHi  = syncB[1];
  wire logic  refLvl = syncB[2];

  always_ff @(posedge mclk)
  begin
    syncA   <= {refClkIn, rstPinIn, supplyOk};
    syncB   <= syncA;
    refPrev <= refLvl;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0]  ctrl;
  logic [4:0]  iStat;
  logic [4:0]  iEn;
  logic        oscStoppedFlag;
  logic        oscAlive;
  logic [7:0]  awAddrQ;
  logic [7:0]  wDataQ;
  logic        wLane0;
  logic        awHave;
  logic        wHave;
  logic [4:0]  events;
  logic        osfSet;
  wire logic   doWr   = awHave && wHave && !bvalid;
  wire logic   wrLow  = doWr && wLane0;
  wire logic   irqOrWaveSelect = ctrl[`RRP_C_IOW];
  wire logic   oscDisable      = ctrl[`RRP_C_ODIS];

  // write address and data taken in either order
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      awHave  <= 1'b0;
      wHave   <= 1'b0;
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= `RRP_RESP_OK;
      awAddrQ <= 8'h00;
      wDataQ  <= 8'h00;
      wLane0  <= 1'b0;
    end
    else
    begin
      // ready never waits on valid low, else a master leading with valid deadlocks
      awready <= !awHave;
      wready  <= !wHave;
      if (awvalid && awready)
      begin
        awHave  <= 1'b1;
        awAddrQ <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready)
      begin
        wHave  <= 1'b1;
        wDataQ <= wdata[7:0];
        wLane0 <= wstrb[0];
        wready <= 1'b0;
      end
      if (doWr)
      begin
        awHave <= 1'b0;
        wHave  <= 1'b0;
        bvalid <= 1'b1;
        case (awAddrQ)
          `RRP_OFF_CTRL, `RRP_OFF_STAT, `RRP_OFF_ICLR, `RRP_OFF_IEN: bresp <= `RRP_RESP_OK;
          default: bresp <= `RRP_RESP_ERR;
        endcase
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  // software state; reset pin level does not reach here
  // only resetn resets
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      ctrl <= `RRP_CTRL_RST;
      iEn  <= `RRP_IEN_RST;
    end
    else if (wrLow && awAddrQ == `RRP_OFF_CTRL)
      ctrl <= wDataQ;
    else if (wrLow && awAddrQ == `RRP_OFF_IEN)
      iEn <= wDataQ[4:0];
  end

  // sticky status, a set beats a clear in the same cycle
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      iStat <= 5'h00;
    else if (wrLow && awAddrQ == `RRP_OFF_ICLR)
      iStat <= (iStat & ~wDataQ[4:0]) | events;
    else
      iStat <= iStat | events;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      irq <= 1'b0;
    else
      irq <= |(iStat & iEn);
  end

  // read channel, one cycle after address
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `RRP_RESP_OK;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= `RRP_RESP_OK;
      case (araddr)
        `RRP_OFF_CTRL:  rdata <= {24'h000000, ctrl};
        `RRP_OFF_STAT:  rdata <= {28'h0000000, oscAlive, supOk, rstPinOe, oscStoppedFlag};
        `RRP_OFF_ISTAT: rdata <= {27'h0000000, iStat};
        `RRP_OFF_IEN:   rdata <= {27'h0000000, iEn};
        `RRP_OFF_ICLR:  rdata <= 32'h0000_0000;
        default:
        begin
          rdata <= 32'h0000_0000;
          rresp <= `RRP_RESP_ERR;
        end
      endcase
    end
    else if (rvalid && rready)
      rvalid <= 1'b0;
    else
      arready <= !rvalid;
  end

  // ----------------------------------------
  // oscillator stop detector
  // ----------------------------------------
  logic [23:0] stopCnt;
  wire logic   refEdge = refLvl ^ refPrev;
  assign osfSet = stopCnt == OSF_CYC - 24'h000001;

  // count mclk cycles with no oscillator edge
  always_ff @(posedge mclk)
  begin
    if (!resetn || refEdge)
      stopCnt <= 24'h000000;
    else if (!osfSet)
      stopCnt <= stopCnt + 24'h000001;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      oscStoppedFlag <= 1'b0;
      oscAlive       <= 1'b0;
    end
    else
    begin
      oscAlive <= refEdge ? 1'b1 : (osfSet ? 1'b0 : oscAlive);
      if (osfSet)
        oscStoppedFlag <= 1'b1;
      else if (wrLow && awAddrQ == `RRP_OFF_STAT && wDataQ[`RRP_S_OSF])
        oscStoppedFlag <= 1'b0;
    end
  end

  // ----------------------------------------
  // reset pin sequencer
  // ----------------------------------------
  rrp_pkg::rrp_state_t state;
  rrp_pkg::rrp_state_t next_state;
  logic [23:0] cnt;
  logic [1:0]  guard;
  wire logic   cntDone = (state == rrp_pkg::ST_DEB   && cnt == DEB_CYC - 24'h000001)
                      || (state == rrp_pkg::ST_REC   && cnt == REC_CYC - 24'h000001)
                      || (state == rrp_pkg::ST_PULSE && cnt == RST_CYC - 24'h000001);

  always_comb
  begin
    next_state = state;
    case (state)
      rrp_pkg::ST_IDLE:
        if (!supOk)
          next_state = rrp_pkg::ST_FAIL;
        else if (!pinHi && guard == `RRP_GUARD)
          next_state = rrp_pkg::ST_DEB;
      rrp_pkg::ST_DEB:
        if (!supOk)
          next_state = rrp_pkg::ST_FAIL;
        else if (pinHi)
          next_state = rrp_pkg::ST_IDLE;
        else if (cntDone)
          next_state = rrp_pkg::ST_PULSE;
      // delay only with oscillator on and running
      rrp_pkg::ST_FAIL:
        if (supOk)
          next_state = (oscDisable || !oscAlive) ? rrp_pkg::ST_IDLE : rrp_pkg::ST_REC;
      rrp_pkg::ST_REC:
        if (!supOk)
          next_state = rrp_pkg::ST_FAIL;
        else if (cntDone)
          next_state = rrp_pkg::ST_IDLE;
      rrp_pkg::ST_PULSE:
        if (!supOk)
          next_state = rrp_pkg::ST_FAIL;
        else if (cntDone)
          next_state = rrp_pkg::ST_IDLE;
      default:
        next_state = rrp_pkg::ST_FAIL;
    endcase
  end

  // guard lets the pin recover after our own release
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      state    <= rrp_pkg::ST_FAIL;
      cnt      <= 24'h000000;
      guard    <= 2'h0;
      rstPinOe <= 1'b1;
    end
    else
    begin
      state <= next_state;
      cnt   <= (next_state != state) ? 24'h000000 : cnt + 24'h000001;
      guard <= (state != rrp_pkg::ST_IDLE) ? 2'h0 : (guard == `RRP_GUARD ? guard : guard + 2'h1);
      // drive low in fail, recovery and pulse
      rstPinOe <= next_state == rrp_pkg::ST_FAIL || next_state == rrp_pkg::ST_REC
               || next_state == rrp_pkg::ST_PULSE;
    end
  end

  always_comb
  begin
    events = 5'h00;
    events[`RRP_EV_A1] = alarm1Match && ctrl[`RRP_C_A1EN];
    events[`RRP_EV_A2] = alarm2Match && ctrl[`RRP_C_A2EN];
    events[`RRP_EV_PF] = next_state == rrp_pkg::ST_FAIL && state != rrp_pkg::ST_FAIL;
    events[`RRP_EV_PB] = state == rrp_pkg::ST_DEB && next_state == rrp_pkg::ST_PULSE;
    events[`RRP_EV_OS] = osfSet && !oscStoppedFlag;
  end

  // ----------------------------------------
  // wave, interrupt and reference pins
  // ----------------------------------------
  logic [23:0] waveCnt;
  logic [23:0] waveHalf;
  logic        wave;
  wire logic   alarmAct = iStat[`RRP_EV_A1] && ctrl[`RRP_C_A1EN]
                       || iStat[`RRP_EV_A2] && ctrl[`RRP_C_A2EN];

  always_comb
  begin
    case ({ctrl[`RRP_C_RSHI], ctrl[`RRP_C_RSLO]})
      2'h0:    waveHalf = W0_HALF;
      2'h1:    waveHalf = W1_HALF;
      2'h2:    waveHalf = 24'(`RRP_HALF(`RRP_RATE2_HZ));
      default: waveHalf = 24'(`RRP_HALF(`RRP_RATE3_HZ));
    endcase
  end

  // divider toggles at each half period
  always_ff @(posedge mclk)
  begin
    if (!resetn || waveCnt >= waveHalf - 24'h000001)
      waveCnt <= 24'h000000;
    else
      waveCnt <= waveCnt + 24'h000001;
    if (!resetn)
      wave <= 1'b0;
    else if (waveCnt >= waveHalf - 24'h000001)
      wave <= !wave;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      intPinOe    <= 1'b0;
      refClkPinOe <= 1'b0;
    end
    else
    begin
      // open drain, low means enable high
      intPinOe    <= irqOrWaveSelect ? alarmAct : !wave;
      // no supply term gates the output
      refClkPinOe <= ctrl[`RRP_C_REFEN] && !refLvl;
    end
  end

  assign rstPinOut    = 1'b0;
  assign intPinOut    = 1'b0;
  assign refClkPinOut = 1'b0;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  property p_wave;
    !irqOrWaveSelect |=> intPinOe == !$past(wave);
  endproperty
  a_wave: assert property (p_wave) else $error("wave pin mismatch");

  property p_alarm;
    irqOrWaveSelect && alarmAct |=> intPinOe;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm not on pin");

  property p_defaults;
    $rose(resetn) |-> irqOrWaveSelect && !ctrl[`RRP_C_A1EN] && !ctrl[`RRP_C_A2EN];
  endproperty
  a_defaults: assert property (p_defaults) else $error("bad power-on defaults");

  property p_fail;
    !supOk |=> rstPinOe && state == rrp_pkg::ST_FAIL;
  endproperty
  a_fail: assert property (p_fail) else $error("reset not held on bad supply");

  property p_pulse;
    state == rrp_pkg::ST_DEB && next_state == rrp_pkg::ST_PULSE |=> rstPinOe [*8];
  endproperty
  a_pulse: assert property (p_pulse) else $error("no pushbutton pulse");

  property p_recover;
    state == rrp_pkg::ST_FAIL && supOk && !oscDisable && oscAlive |=> rstPinOe [*8];
  endproperty
  a_recover: assert property (p_recover) else $error("recovery delay skipped");

  property p_bypass;
    state == rrp_pkg::ST_FAIL && supOk && oscDisable |=> !rstPinOe;
  endproperty
  a_bypass: assert property (p_bypass) else $error("release not immediate");

  property p_osf;
    $rose(oscStoppedFlag) |-> $past(stopCnt) == OSF_CYC - 24'h000001;
  endproperty
  a_osf: assert property (p_osf) else $error("stop flag set early");

  property p_ref;
    ctrl[`RRP_C_REFEN] |=> refClkPinOe == !$past(refLvl);
  endproperty
  a_ref: assert property (p_ref) else $error("ref clock not driven");

  c_pb:   cover property (state == rrp_pkg::ST_DEB ##1 state == rrp_pkg::ST_PULSE);
  c_rec:  cover property (state == rrp_pkg::ST_REC ##1 state == rrp_pkg::ST_IDLE);
  c_osf:  cover property ($rose(oscStoppedFlag));
  c_irq:  cover property ($rose(irq));
endmodule

// [dv/rrp_host_model.sv]
// Purpose: host side of the reset, interrupt and ref clock pins
// Assumes: pullups on all three open-drain lines
// Notes:   pushbutton is a switch to ground on the reset line
`timescale 1ns/1ps
module rrp_host_model
(
  input  wire logic mclk,
  input  wire logic rstPinOe,
  input  wire logic intPinOe,
  input  wire logic refClkPinOe,
  output logic      rstPinIn,
  output logic      rstLevel,
  output logic      intLevel,
  output logic      refLevel
);
  logic pbDown;

  initial pbDown = 1'b0;
  assign rstLevel = !(rstPinOe || pbDown);
  assign rstPinIn = rstLevel;
  assign intLevel = !intPinOe;
  assign refLevel = !refClkPinOe;

  task automatic press(input int n);
    @(posedge mclk);
    pbDown <= 1'b1;
    repeat (n) @(posedge mclk);
    pbDown <= 1'b0;
  endtask
endmodule

// [dv/tb.sv]
// Purpose: self-checking bench for the reset and pin block
// Assumes: short counts, ref oscillator made by the bench
// Notes:   one bus access at a time
`timescale 1ns/1ps
`include "rrp_map.svh"
module tb;
  // ----------
  // signals
  // ----------
  localparam logic [23:0] RST = 24'h000014;
  localparam logic [23:0] REC = 24'h000014;
  localparam logic [23:0] DEB = 24'h000014;
  logic        mclk, resetn, awvalid, wvalid, bready, arvalid, rready, bvalid, rvalid;
  logic        supplyOk, alarm1Match, alarm2Match, refClkIn, refRun, awready, wready;
  logic        arready, rstPinIn, rstPinOe, intPinOe, refClkPinOe, irq, rstLevel, intLevel;
  logic [7:0]  awaddr, araddr;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] wdata, rdata, d;
  logic [31:0] hTab [4];
  int          nFail, nCompared, c;

  rrp_pins
  #(
    .RST_CYC (RST),
    .REC_CYC (REC),
    .DEB_CYC (DEB),
    .OSF_CYC (24'h000010),
    .W0_HALF (24'h000008),
    .W1_HALF (24'h000006)
  )
  u_rrp_pins
  (
    .mclk         (mclk),
    .resetn       (resetn),
    .awaddr       (awaddr),
    .awvalid      (awvalid),
    .awready      (awready),
    .wdata        (wdata),
    .wstrb        (wstrb),
    .wvalid       (wvalid),
    .wready       (wready),
    .bresp        (bresp),
    .bvalid       (bvalid),
    .bready       (bready),
    .araddr       (araddr),
    .arvalid      (arvalid),
    .arready      (arready),
    .rdata        (rdata),
    .rresp        (rresp),
    .rvalid       (rvalid),
    .rready       (rready),
    .supplyOk     (supplyOk),
    .alarm1Match  (alarm1Match),
    .alarm2Match  (alarm2Match),
    .refClkIn     (refClkIn),
    .rstPinIn     (rstPinIn),
    .rstPinOut    (),
    .rstPinOe     (rstPinOe),
    .intPinOut    (),
    .intPinOe     (intPinOe),
    .refClkPinOut (),
    .refClkPinOe  (refClkPinOe),
    .irq          (irq)
  );

  rrp_host_model u_rrp_host_model
  (
    .mclk        (mclk),
    .rstPinOe    (rstPinOe),
    .intPinOe    (intPinOe),
    .refClkPinOe (refClkPinOe),
    .rstPinIn    (rstPinIn),
    .rstLevel    (rstLevel),
    .intLevel    (intLevel),
    .refLevel    ()
  );

  initial mclk = 1'b0;
  always #25 mclk = ~mclk;
  // ref oscillator stands still when stopped on purpose
  always
  begin
    repeat (5) @(posedge mclk);
    if (refRun) refClkIn <= ~refClkIn;
  end

  // ----------
  // tasks
  // ----------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp)
    begin
      nFail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    resp = bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    resp = rresp;
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(d & m, e);
  endtask

  // cycles the reset pin stays driven
  task automatic highLen();
    c = 0;
    while (rstPinOe === 1'b1)
    begin
      @(posedge mclk);
      c++;
    end
  endtask

  // one half period of the shared pin, edge to edge
  task automatic half();
    logic v;
    @(posedge mclk);
    v = intPinOe;
    while (intPinOe === v) @(posedge mclk);
    v = intPinOe;
    c = 0;
    while (intPinOe === v)
    begin
      @(posedge mclk);
      c++;
    end
  endtask

  // pickRst selects the reset pin enable, else the ref clock enable
  task automatic countHigh(input int n, input bit pickRst);
    c = 0;
    repeat (n)
    begin
      @(posedge mclk);
      c += int'((pickRst ? rstPinOe : refClkPinOe) === 1'b1);
    end
  endtask

  task automatic endTest(input string s);
    $display("test %s done", s);
  endtask

  task automatic testDone();
    $display("compared %0d, mismatches %0d", nCompared, nFail);
    if (nFail == 0 && nCompared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ----------
  // tests
  // ----------
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, alarm1Match, alarm2Match} = '0;
    {awaddr, araddr, wdata, refClkIn, resetn} = '0;
    wstrb = 4'hF;
    supplyOk = 1'b1;
    refRun = 1'b1;
    nFail = 0;
    nCompared = 0;
    hTab = '{32'h8, 32'h6, `RRP_HALF(`RRP_RATE2_HZ), `RRP_HALF(`RRP_RATE3_HZ)};
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    repeat (12) @(posedge mclk);
    chk(rstLevel, 1'b1);
    rdChk(`RRP_OFF_CTRL, 32'hFF, 32'h24);
    chk(intPinOe, 1'b0);
    rdChk(`RRP_OFF_STAT, 32'h1, 32'h0);
    rd(8'h14);
    chk(resp, `RRP_RESP_ERR);
    chk(d, 32'h0);
    wr(8'h14, 32'h0);
    chk(resp, `RRP_RESP_ERR);
    endTest("reset");
    wr(`RRP_OFF_CTRL, 32'h25);
    alarm2Match <= 1'b1;
    repeat (3) @(posedge mclk);
    alarm2Match <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(intPinOe, 1'b0);
    alarm1Match <= 1'b1;
    repeat (3) @(posedge mclk);
    alarm1Match <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(intLevel, 1'b0);
    chk(irq, 1'b0);
    wr(`RRP_OFF_IEN, 32'h1);
    repeat (2) @(posedge mclk);
    chk(irq, 1'b1);
    wr(`RRP_OFF_ICLR, 32'h1F);
    repeat (2) @(posedge mclk);
    chk(irq, 1'b0);
    chk(intPinOe, 1'b0);
    endTest("alarm");
    for (int r = 0; r < 4; r++)
    begin
      wr(`RRP_OFF_CTRL, 32'h20 | 32'(r << 3));
      half();
      chk(c, hTab[r]);
    end
    wr(`RRP_OFF_CTRL, 32'h24);
    endTest("wave");
    rdChk(`RRP_OFF_STAT, 32'h8, 32'h8);
    supplyOk <= 1'b0;
    repeat (5) @(posedge mclk);
    chk(rstLevel, 1'b0);
    rdChk(`RRP_OFF_CTRL, 32'hFF, 32'h24);
    countHigh(40, 1'b0);
    chk(c > 5, 1'b1);
    supplyOk <= 1'b1;
    highLen();
    chk(c >= REC && c <= REC + 6, 1'b1);
    rdChk(`RRP_OFF_ISTAT, 32'h4, 32'h4);
    wr(`RRP_OFF_CTRL, 32'hA4);
    supplyOk <= 1'b0;
    repeat (6) @(posedge mclk);
    chk(rstLevel, 1'b0);
    supplyOk <= 1'b1;
    highLen();
    chk(c <= 6, 1'b1);
    wr(`RRP_OFF_CTRL, 32'h24);
    endTest("supply");
    repeat (10) @(posedge mclk);
    fork
      u_rrp_host_model.press(int'(DEB) + 12);
    join_none
    while (rstPinOe !== 1'b1) @(posedge mclk);
    highLen();
    chk(c >= RST && c <= RST + 2, 1'b1);
    rdChk(`RRP_OFF_ISTAT, 32'h8, 32'h8);
    repeat (10) @(posedge mclk);
    u_rrp_host_model.press(5);
    countHigh(40, 1'b1);
    chk(c, 32'h0);
    endTest("pushbutton");
    refRun <= 1'b0;
    repeat (4) @(posedge mclk);
    rdChk(`RRP_OFF_STAT, 32'h1, 32'h0);
    repeat (30) @(posedge mclk);
    rdChk(`RRP_OFF_STAT, 32'h1, 32'h1);
    rdChk(`RRP_OFF_ISTAT, 32'h10, 32'h10);
    refRun <= 1'b1;
    repeat (20) @(posedge mclk);
    wr(`RRP_OFF_STAT, 32'h1);
    rdChk(`RRP_OFF_STAT, 32'h1, 32'h0);
    wr(`RRP_OFF_CTRL, 32'h04);
    countHigh(30, 1'b0);
    chk(c, 32'h0);
    endTest("oscillator");
    testDone();
  end

  // hang guard, several times the expected run
  initial
  begin
    repeat (40000) @(posedge mclk);
    nFail++;
    testDone();
  end
endmodule
